// File: verilog/reset_cause_and_interrupt_ctrl.sv
// reset-cause tracking and interrupt arbitration for the core sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_interrupt_ctrl (
	// clock and power-on reset
	input  wire logic                                 clock,
	input  wire logic                                 rst_n,
	// option and port configuration
	input  wire logic                                 reset_pin_opt,
	input  wire logic                                 ext_irq_sel,
	input  wire logic [irq_reset_pkg::PORT_W-1:0]     port_dir_out,
	// port pins, asynchronous
	input  wire logic [irq_reset_pkg::PORT_W-1:0]     port_pin,
	// on-chip events
	input  wire logic                                 timer_overflow,
	input  wire logic                                 watchdog_timeout,
	// core sequencer operations
	input  wire irq_reset_pkg::core_op_t              core_op,
	input  wire logic [irq_reset_pkg::FLAG_W-1:0]     flag_wdata,
	input  wire logic [irq_reset_pkg::FLAG_W-1:0]     mask_wdata,
	// status to the core
	output irq_reset_pkg::cause_t                     cause,
	output logic      [irq_reset_pkg::FLAG_W-1:0]     irq_flag_reg,
	output logic      [irq_reset_pkg::FLAG_W-1:0]     irq_mask_reg,
	output logic      [irq_reset_pkg::FLAG_W-1:0]     irq_request,
	output logic      [irq_reset_pkg::PORT_W-1:0]     port_level,
	output logic                                      global_enable,
	output logic                                      asleep,
	// sequencer control
	output irq_reset_pkg::vector_t                    vector,
	output logic                                      core_reset,
	output logic                                      wake
);
	import irq_reset_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ctrl_state_t       r;          // registered state
	ctrl_state_t       next_r;     // next state
	logic [PORT_W-1:0] level;      // filtered pin levels
	logic [PORT_W-1:0] eligible;   // pins watched for change
	logic [PORT_W-1:0] changed;    // eligible pins differing from copy
	logic              change_any; // any eligible change
	logic              rst_lvl;    // effective reset line level
	logic              pin_fall;   // reset line went low
	logic              ext_fall;   // external interrupt edge
	logic [FLAG_W-1:0] set_vec;    // hardware flag sets this cycle
	logic [FLAG_W-1:0] req;        // masked requests
	logic              take_sw;    // software interrupt taken
	logic              take_hw;    // hardware interrupt taken
	logic              reset_ev;   // any reset action this cycle

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	pin_sync u_sync (
		.clock     (clock),
		.rst_n     (rst_n),
		.pin_raw   (port_pin),
		.pin_level (level)
	);

	// pin mask helper, used for both excluded pins
	function automatic logic [PORT_W-1:0] pin_bit(input logic on, input int idx);
		logic [PORT_W-1:0] m;
		m      = PORT_NONE;
		m[idx] = on;
		return m;
	endfunction

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	always_comb begin
		// option 1 ties the internal line high, pin becomes a port bit
		rst_lvl    = level[PIN_RST] | (reset_pin_opt != OPT_PIN_RESET);
		pin_fall   = r.rst_prev & ~rst_lvl;
		// outputs, interrupt pin and active reset pin are not watched
		eligible   = ~port_dir_out & ~pin_bit(ext_irq_sel, PIN_EXT)
			& ~pin_bit(reset_pin_opt == OPT_PIN_RESET, PIN_RST);
		changed    = (level ^ r.copy) & eligible;
		change_any = |changed;
		ext_fall   = ext_irq_sel & r.ext_prev & ~level[PIN_EXT];
		// port change only counts when its mask bit is set
		set_vec            = FLAG_NONE;
		set_vec[FLAG_TMR]  = timer_overflow;
		set_vec[FLAG_PORT] = change_any & r.mask[FLAG_PORT];
		set_vec[FLAG_EXT]  = ext_fall;
		req        = r.flag & r.mask;
		reset_ev   = pin_fall | (r.mode == MODE_HOLD) | watchdog_timeout;
		// instruction wins a tie so the executed opcode is honoured
		take_sw    = ~reset_ev & (r.mode == MODE_RUN) & r.gie & core_op.sw_irq_instr;
		take_hw    = ~reset_ev & (r.mode == MODE_RUN) & r.gie & ~take_sw & (|req);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r           = r;
		next_r.vec.valid = 1'h0;
		next_r.wake      = 1'h0;
		next_r.core_reset = 1'h0;
		next_r.rst_prev  = rst_lvl;
		next_r.ext_prev  = level[PIN_EXT];
		// copy for change detection, refreshed on each port read
		if (core_op.port_read) begin
			next_r.copy = level;
		end
		// software write first, then hardware set so a set wins
		if (core_op.flag_write) begin
			next_r.flag = flag_wdata;
		end
		next_r.flag = next_r.flag | set_vec;
		if (core_op.mask_write) begin
			next_r.mask = mask_wdata;
		end
		if (pin_fall) begin
			// reset pin pulse: hold the core until the line returns
			next_r.mode       = MODE_HOLD;
			next_r.core_reset = 1'h1;
			next_r.flag       = FLAG_NONE;
			next_r.mask       = FLAG_NONE;
			next_r.gie        = 1'h0;
			if (r.mode == MODE_SLEEP) begin
				next_r.cause = CAUSE_PIN_SLEEP;
			end else begin
				next_r.cause.pin_wake = 1'h0;
			end
		end else if (r.mode == MODE_HOLD) begin
			// still low: keep the core in reset, release on the rise
			next_r.core_reset = ~rst_lvl;
			next_r.flag       = FLAG_NONE;
			if (rst_lvl) begin
				next_r.mode = MODE_RUN;
			end
		end else if (watchdog_timeout) begin
			// watchdog expiry: one-cycle core reset
			next_r.mode       = MODE_RUN;
			next_r.core_reset = 1'h1;
			next_r.flag       = FLAG_NONE;
			next_r.mask       = FLAG_NONE;
			next_r.gie        = 1'h0;
			if (r.mode == MODE_SLEEP) begin
				next_r.cause = CAUSE_WDT_SLEEP;
			end else begin
				next_r.cause.pin_wake = 1'h0;
				next_r.cause.timeout  = 1'h0;
			end
		end else if (r.mode == MODE_SLEEP) begin
			// only an enabled port change wakes the core
			if (change_any & r.mask[FLAG_PORT]) begin
				next_r.mode  = MODE_RUN;
				next_r.cause = CAUSE_CHANGE;
				next_r.wake  = 1'h1;
				if (r.gie) begin
					next_r.vec.valid = 1'h1;
					next_r.vec.addr  = VEC_HW;
					next_r.gie       = 1'h0;
				end
			end
		end else begin
			// running: instruction side effects
			if (core_op.watchdog_clear_instr) begin
				next_r.cause.timeout    = 1'h1;
				next_r.cause.power_down = 1'h1;
			end
			if (core_op.sleep_instr) begin
				next_r.cause.timeout    = 1'h1;
				next_r.cause.power_down = 1'h0;
				next_r.mode             = MODE_SLEEP;
			end
			if (core_op.irq_enable_instr | core_op.irq_return_instr) begin
				next_r.gie = 1'h1;
			end
			if (core_op.irq_disable_instr) begin
				next_r.gie = 1'h0;
			end
			// entry clears the enable, blocking nested entry
			if (take_sw) begin
				next_r.vec.valid = 1'h1;
				next_r.vec.addr  = VEC_SW;
				next_r.gie       = 1'h0;
			end else if (take_hw) begin
				next_r.vec.valid = 1'h1;
				next_r.vec.addr  = VEC_HW;
				next_r.gie       = 1'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// state register; power-on loads the power-on causes
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= CTRL_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cause         = r.cause;
	assign irq_flag_reg  = r.flag;
	assign irq_mask_reg  = r.mask;
	assign irq_request   = req;
	assign port_level    = level;
	assign global_enable = r.gie;
	assign asleep        = (r.mode == MODE_SLEEP);
	assign vector        = r.vec;
	assign core_reset    = r.core_reset;
	assign wake          = r.wake;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_por;
		$rose(rst_n) |-> (r.cause == CAUSE_POR) && core_reset;
	endproperty
	a_por: assert property (p_por) else $error("power-on causes wrong");

	property p_pin_run;
		pin_fall && (r.mode == MODE_RUN) |=> core_reset && !cause.pin_wake
			&& (cause.timeout == $past(cause.timeout)) && (cause.power_down == $past(cause.power_down));
	endproperty
	a_pin_run: assert property (p_pin_run) else $error("pin reset while running wrong");

	property p_pin_sleep;
		pin_fall && asleep |=> (cause == CAUSE_PIN_SLEEP) && !asleep;
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("pin reset from sleep wrong");

	property p_wdt_run;
		watchdog_timeout && !pin_fall && (r.mode == MODE_RUN)
			|=> core_reset && !cause.pin_wake && !cause.timeout && (cause.power_down == $past(cause.power_down));
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset while running wrong");

	property p_wdt_sleep;
		watchdog_timeout && !pin_fall && asleep |=> (cause == CAUSE_WDT_SLEEP) ##1 !core_reset;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog wake wrong");

	property p_change_wake;
		asleep && !reset_ev && change_any && r.mask[FLAG_PORT]
			|=> wake && (cause == CAUSE_CHANGE) && (vector.valid == $past(r.gie)) && !global_enable;
	endproperty
	a_change_wake: assert property (p_change_wake) else $error("pin change wake wrong");

	property p_sleep_instr;
		core_op.sleep_instr && !reset_ev && (r.mode == MODE_RUN)
			|=> asleep && cause.timeout && !cause.power_down && $stable(cause.pin_wake);
	endproperty
	a_sleep_instr: assert property (p_sleep_instr) else $error("sleep instruction wrong");

	property p_enable;
		(core_op.irq_enable_instr || core_op.irq_return_instr) && !core_op.irq_disable_instr
			&& !take_sw && !take_hw && !reset_ev && (r.mode == MODE_RUN) |=> global_enable;
	endproperty
	a_enable: assert property (p_enable) else $error("global enable not set");

	property p_hw_vec;
		take_hw |=> vector.valid && (vector.addr == VEC_HW) && !global_enable ##1 !vector.valid;
	endproperty
	a_hw_vec: assert property (p_hw_vec) else $error("hardware vector wrong");

	property p_sw_vec;
		take_sw |=> vector.valid && (vector.addr == VEC_SW) && !global_enable;
	endproperty
	a_sw_vec: assert property (p_sw_vec) else $error("software vector wrong");

	property p_flag_set;
		timer_overflow && !reset_ev |=> irq_flag_reg[FLAG_TMR];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("timer flag lost");

	// ----------------------------------------------------------------
	// further checks on events, writes and the option bit
	// ----------------------------------------------------------------
	// disable must win even against a same-cycle enable or return
	property p_disable;
		core_op.irq_disable_instr && !reset_ev && (r.mode == MODE_RUN) |=> !global_enable;
	endproperty
	a_disable: assert property (p_disable) else $error("global enable not cleared");

	property p_ext_flag;
		ext_fall && !reset_ev |=> irq_flag_reg[FLAG_EXT];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external flag lost");

	property p_port_flag;
		change_any && r.mask[FLAG_PORT] && !reset_ev |=> irq_flag_reg[FLAG_PORT];
	endproperty
	a_port_flag: assert property (p_port_flag) else $error("port change flag lost");

	// with no hardware set in that cycle, a write lands as written
	property p_flag_write;
		core_op.flag_write && !reset_ev && !timer_overflow && !ext_fall
			&& !(change_any && r.mask[FLAG_PORT]) |=> irq_flag_reg == $past(flag_wdata);
	endproperty
	a_flag_write: assert property (p_flag_write) else $error("flag write lost");

	property p_mask_write;
		core_op.mask_write && !reset_ev |=> irq_mask_reg == $past(mask_wdata);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	// the core stays held for as long as the reset line is low
	property p_hold;
		(r.mode == MODE_HOLD) && !rst_lvl |=> core_reset && (irq_flag_reg == FLAG_NONE);
	endproperty
	a_hold: assert property (p_hold) else $error("core released while reset line low");

	property p_wdt_clear;
		watchdog_timeout && !pin_fall && (r.mode != MODE_HOLD)
			|=> core_reset && (irq_mask_reg == FLAG_NONE) && !global_enable;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog reset incomplete");

	// a falling reset pin must reach the core when the option enables it
	property p_opt_reset;
		(reset_pin_opt == OPT_PIN_RESET) && ($past(reset_pin_opt) == OPT_PIN_RESET)
			&& $fell(port_level[PIN_RST]) |=> core_reset;
	endproperty
	a_opt_reset: assert property (p_opt_reset) else $error("reset pin fall ignored");

	// with the option set a low pin is only a port bit
	property p_opt_port;
		(reset_pin_opt != OPT_PIN_RESET) && (r.mode == MODE_RUN) && !watchdog_timeout |=> !core_reset;
	endproperty
	a_opt_port: assert property (p_opt_port) else $error("reset from a plain port bit");

	property p_no_entry;
		!global_enable |=> !vector.valid;
	endproperty
	a_no_entry: assert property (p_no_entry) else $error("entry with global enable off");

	property p_wake_pulse;
		wake |-> !asleep ##1 !wake;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse wrong");

	// the change reference is the level seen at the read
	property p_copy;
		core_op.port_read |=> r.copy == $past(level);
	endproperty
	a_copy: assert property (p_copy) else $error("port copy not refreshed");

endmodule
`default_nettype wire

// File: verilog/irq_reset_pkg.sv
// constants, types and carriers shared by the reset-cause and interrupt block
package irq_reset_pkg;

	// ----------------------------------------------------------------
	// widths and pin positions
	// ----------------------------------------------------------------
	localparam int PORT_W    = 8;               // input port width
	localparam int VEC_W     = 10;              // program address width
	localparam int FLAG_W    = 3;               // interrupt sources
	localparam int FLAG_TMR  = 0;               // timer overflow flag bit
	localparam int FLAG_PORT = 1;               // port change flag bit
	localparam int FLAG_EXT  = 2;               // external pin flag bit
	localparam int PIN_EXT   = 0;               // port bit zero, external interrupt
	localparam int PIN_RST   = 3;               // port bit three, alternate reset pin

	// ----------------------------------------------------------------
	// option, vectors and reset values
	// ----------------------------------------------------------------
	localparam logic             OPT_PIN_RESET = 1'h0;    // option value enabling the reset pin
	localparam logic [VEC_W-1:0] VEC_HW        = 10'h008; // hardware interrupt entry
	localparam logic [VEC_W-1:0] VEC_SW        = 10'h001; // software interrupt entry
	localparam logic [PORT_W-1:0] PORT_IDLE    = 8'hFF;   // pins idle high after reset
	localparam logic [PORT_W-1:0] PORT_NONE    = 8'h00;
	localparam logic [FLAG_W-1:0] FLAG_NONE    = 3'h0;

	// ----------------------------------------------------------------
	// reset cause bits: pin-change wake, time-out, power-down
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pin_wake;
		logic timeout;
		logic power_down;
	} cause_t;

	localparam cause_t CAUSE_POR       = 3'h3; // 0 1 1
	localparam cause_t CAUSE_PIN_SLEEP = 3'h2; // 0 1 0
	localparam cause_t CAUSE_WDT_SLEEP = 3'h0; // 0 0 0
	localparam cause_t CAUSE_CHANGE    = 3'h6; // 1 1 0

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_HOLD
	} mode_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic watchdog_clear_instr;
		logic sleep_instr;
		logic irq_enable_instr;
		logic irq_disable_instr;
		logic irq_return_instr;
		logic sw_irq_instr;
		logic port_read;
		logic flag_write;
		logic mask_write;
	} core_op_t;

	typedef struct packed {
		logic             valid;
		logic [VEC_W-1:0] addr;
	} vector_t;

	typedef struct packed {
		logic [PORT_W-1:0] s1;
		logic [PORT_W-1:0] s2;
		logic [PORT_W-1:0] s3;
		logic [PORT_W-1:0] level;
	} sync_state_t;

	localparam sync_state_t SYNC_RESET = {PORT_IDLE, PORT_IDLE, PORT_IDLE, PORT_IDLE};

	typedef struct packed {
		mode_t             mode;
		cause_t            cause;
		logic [FLAG_W-1:0] flag;
		logic [FLAG_W-1:0] mask;
		logic              gie;
		logic [PORT_W-1:0] copy;
		logic              rst_prev;
		logic              ext_prev;
		logic              core_reset;
		logic              wake;
		vector_t           vec;
	} ctrl_state_t;

	localparam ctrl_state_t CTRL_RESET = {MODE_RUN, CAUSE_POR, FLAG_NONE, FLAG_NONE, 1'h0,
		PORT_IDLE, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 10'h000};

endpackage

// File: verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	// raw pins
	input  wire logic [irq_reset_pkg::PORT_W-1:0] pin_raw,
	// filtered levels
	output logic      [irq_reset_pkg::PORT_W-1:0] pin_level
);
	import irq_reset_pkg::*;

	sync_state_t r;      // registered state
	sync_state_t next_r; // next state

	// ----------------------------------------------------------------
	// shift chain; level moves only when stages two and three agree
	// ----------------------------------------------------------------
	always_comb begin
		next_r    = r;
		next_r.s1 = pin_raw;
		next_r.s2 = r.s1;    // first stage feeds nothing else
		next_r.s3 = r.s2;
		for (int i = 0; i < PORT_W; i++) begin
			// a glitch of one cycle never reaches the level
			if (r.s2[i] == r.s3[i]) begin
				next_r.level[i] = r.s3[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// state register, idles high so no false edge after reset
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= SYNC_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign pin_level = r.level;

endmodule
`default_nettype wire

// File: tb/port_pin_model.sv
// port pin model standing outside the block: bench-driven inputs, toggling outputs
`timescale 1ns/1ps
`default_nettype none
module port_pin_model (
	// clock
	input  wire logic       clock,
	// wanted input levels and pin directions
	input  wire logic [7:0] pin_drive,
	input  wire logic [7:0] dir_out,
	// pins seen by the block
	output logic      [7:0] port_pin
);
	// ----------------------------------------------------------------
	// pin levels
	// ----------------------------------------------------------------
	logic [7:0] wobble = 8'h55; // pattern on pins the chip drives itself
	logic [2:0] beat   = 3'h0;  // slows the wobble past the pin filter

	// output pins keep moving, slowly enough to pass the filter,
	// so a detector that forgets them is caught
	always @(posedge clock) begin
		beat <= beat + 3'h1;
		if (beat == 3'h7) begin
			wobble <= ~wobble;
		end
	end

	// inputs follow the bench, outputs show the wobble pattern
	assign port_pin = (pin_drive & ~dir_out) | (wobble & dir_out);
endmodule
`default_nettype wire

// File: tb/reset_cause_and_interrupt_ctrl_test.sv
// self-checking bench for reset-cause tracking and interrupt arbitration
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_interrupt_ctrl_test;
	import irq_reset_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic              clock = 1'h0;
	logic              rst_n = 1'h0;
	logic              reset_pin_opt = 1'h0;
	logic              ext_irq_sel = 1'h0;
	logic [PORT_W-1:0] port_dir_out = 8'h00;
	logic [PORT_W-1:0] pin_drive = 8'hFF;  // wanted pin levels
	logic [PORT_W-1:0] port_pin;
	logic              timer_overflow = 1'h0;
	logic              watchdog_timeout = 1'h0;
	core_op_t          core_op = '0;
	logic [FLAG_W-1:0] wdata = 3'h0;       // shared flag and mask write data
	cause_t            cause;
	logic [FLAG_W-1:0] irq_flag_reg;
	logic [FLAG_W-1:0] irq_mask_reg;
	logic [FLAG_W-1:0] irq_request;
	logic [PORT_W-1:0] port_level;
	logic              global_enable;
	logic              asleep;
	vector_t           vector;
	logic              core_reset;
	logic              wake;
	int                errors = 0;
	int                compares = 0;
	int                cycles = 0;
	logic [3:0]        vec_count = 4'h0;   // vector pulses seen
	logic [3:0]        wake_count = 4'h0;  // wake pulses seen
	logic [VEC_W-1:0]  vec_addr = 10'h000; // address of the last one
	// op codes in core_op bit order
	localparam logic [8:0] OP_WDC = 9'h100, OP_SLP = 9'h080, OP_EN = 9'h040, OP_DIS = 9'h020;
	localparam logic [8:0] OP_RET = 9'h010, OP_SW = 9'h008, OP_RD = 9'h004, OP_FW = 9'h002, OP_MW = 9'h001;

	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	reset_cause_and_interrupt_ctrl dut (.clock(clock), .rst_n(rst_n), .reset_pin_opt(reset_pin_opt),
		.ext_irq_sel(ext_irq_sel), .port_dir_out(port_dir_out), .port_pin(port_pin),
		.timer_overflow(timer_overflow), .watchdog_timeout(watchdog_timeout), .core_op(core_op),
		.flag_wdata(wdata), .mask_wdata(wdata), .cause(cause), .irq_flag_reg(irq_flag_reg),
		.irq_mask_reg(irq_mask_reg), .irq_request(irq_request), .port_level(port_level),
		.global_enable(global_enable), .asleep(asleep), .vector(vector), .core_reset(core_reset),
		.wake(wake));
	port_pin_model pins (.clock(clock), .pin_drive(pin_drive), .dir_out(port_dir_out), .port_pin(port_pin));

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// vector pulses last one cycle, so count them as they pass
	always @(posedge clock) begin
		cycles++;
		if (vector.valid === 1'b1) begin
			vec_count++;
			vec_addr = vector.addr;
		end
		if (wake === 1'b1) begin
			wake_count++;
		end
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// wait edges, then let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// one-cycle core operation with its write data
	task automatic op(input logic [8:0] b, input logic [FLAG_W-1:0] d);
		@(posedge clock);
		core_op <= core_op_t'(b);
		wdata <= d;
		@(posedge clock);
		core_op <= '0;
		#1;
	endtask

	// one-cycle on-chip event pulses
	task automatic event_pulse(input logic tmr, input logic wdt);
		@(posedge clock);
		timer_overflow <= tmr;
		watchdog_timeout <= wdt;
		@(posedge clock);
		timer_overflow <= 1'h0;
		watchdog_timeout <= 1'h0;
		#1;
	endtask

	// move one pin, give the synchroniser time to settle
	task automatic pin(input int idx, input logic lvl);
		@(posedge clock);
		pin_drive[idx] <= lvl;
		tick(8);
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		tick(1);
		check(cause, CAUSE_POR);
		check({irq_flag_reg, global_enable}, 4'h0);
		// timer flag sets with mask and global enable off; request gated
		event_pulse(1'h1, 1'h0);
		tick(1);
		check({irq_flag_reg, irq_request}, 6'h08);
		op(OP_MW, 3'h1);
		check({irq_mask_reg, irq_request}, 6'h09);
		// enabling with a pending request enters at the hardware vector
		op(OP_EN, 3'h0);
		check(global_enable, 1'h1);
		tick(3);
		check({vec_count, vec_addr}, {4'h1, VEC_HW});
		check(global_enable, 1'h0);
		op(OP_FW, 3'h0); // serviced flag cleared before return
		op(OP_RET, 3'h0);
		check(global_enable, 1'h1);
		tick(3);
		check(vec_count, 4'h1);
		op(OP_DIS, 3'h0);
		check(global_enable, 1'h0);
		op(OP_EN, 3'h0);
		op(OP_SW, 3'h0);
		tick(2);
		check({vec_count, vec_addr, global_enable}, {4'h2, VEC_SW, 1'h0});
		// change detect skips output pins and the interrupt pin
		@(posedge clock);
		port_dir_out <= 8'hF0;
		ext_irq_sel <= 1'h1;
		op(OP_MW, 3'h2);
		op(OP_RD, 3'h0); // port read before the change interrupt matters
		op(OP_FW, 3'h0);
		pin(0, 1'h0);
		check(irq_flag_reg, 3'h4);
		check(port_level[3:0], 4'hE);
		pin(1, 1'h0);
		check({irq_flag_reg, irq_request}, 6'h32);
		pin(0, 1'h1);
		pin(1, 1'h1);
		op(OP_RD, 3'h0);
		op(OP_FW, 3'h0);
		tick(4);
		check(irq_flag_reg, 3'h0);
		// pin change wakes from sleep; in-line when globally disabled
		op(OP_SLP, 3'h0);
		check({asleep, cause}, 4'hA);
		pin(2, 1'h0);
		check({asleep, cause, vec_count}, {1'h0, CAUSE_CHANGE, 4'h2});
		check(wake_count, 4'h1);
		op(OP_RD, 3'h0);
		op(OP_FW, 3'h0);
		op(OP_EN, 3'h0);
		op(OP_SLP, 3'h0);
		pin(2, 1'h1);
		check({vec_count, vec_addr, global_enable}, {4'h3, VEC_HW, 1'h0});
		check(wake_count, 4'h2);
		// reset pin while running keeps time-out and power-down
		pin(3, 1'h0);
		check({core_reset, cause}, 4'hA);
		pin(3, 1'h1);
		check({core_reset, irq_mask_reg}, 4'h0);
		op(OP_WDC, 3'h0);
		check(cause, 3'h3);
		event_pulse(1'h0, 1'h1);
		check({core_reset, cause}, 4'h9);
		tick(1);
		check(core_reset, 1'h0);
		op(OP_SLP, 3'h0);
		event_pulse(1'h0, 1'h1);
		check(cause, CAUSE_WDT_SLEEP);
		tick(2);
		op(OP_SLP, 3'h0);
		pin(3, 1'h0);
		pin(3, 1'h1);
		check({asleep, cause}, {1'h0, CAUSE_PIN_SLEEP});
		// option set: the pin is a plain port bit
		@(posedge clock);
		reset_pin_opt <= 1'h1;
		op(OP_WDC, 3'h0);
		pin(3, 1'h0);
		check({core_reset, cause}, 4'h3);
		pin(3, 1'h1);
		report_and_stop();
	end
endmodule
`default_nettype wire
